// *** tb/crf_mem_model.sv ***
// memory model feeding load data to the register file
`timescale 1ns/100ps
`default_nettype none
module crf_mem_model (
   // clock
   input  wire logic        clk,
   // read port, one cycle latency like a real bus
   input  wire logic [1:0]  addr,
   output logic      [31:0] rdata
);
   logic [31:0] mem [4];
   initial mem = '{32'h0000_0080, 32'h0000_8001, 32'h1234_5678,
                   32'h0000_007f};
   always_ff @(posedge clk) rdata <= mem[addr];
endmodule // crf_mem_model
`default_nettype wire

// *** tb/crf_register_file_sva.sv ***
// port assertions for the register file
`timescale 1ns/100ps
`default_nettype none
module crf_register_file_sva (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // watched ports
   input wire logic                  ldValid,
   input wire crf_pkg::crf_size_t    ldSize,
   input wire logic [31:0]           ldRaw,
   input wire logic [31:0]           ldExt,
   input wire logic [15:0]           instr,
   input wire crf_pkg::crf_immext_t  immKind,
   input wire logic [31:0]           immExt,
   input wire crf_pkg::crf_mem_req_t memReq,
   input wire logic                  addrError,
   input wire logic [31:0]           statusWord,
   input wire logic [31:0]           vectorBase
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_byte_ext: assert property (ldValid &&
      ldSize == crf_pkg::CRF_SZ_BYTE |=> ldExt == {{24{$past(ldRaw[7])}},
      $past(ldRaw[7:0])}) else $error("byte load not sign extended");
   a_word_ext: assert property (ldValid &&
      ldSize == crf_pkg::CRF_SZ_WORD |=> ldExt == {{16{$past(ldRaw[15])}},
      $past(ldRaw[15:0])}) else $error("word load not sign extended");
   a_imm_sign: assert property (immKind == crf_pkg::CRF_IMM_SIGN |=>
      immExt == {{24{$past(instr[7])}}, $past(instr[7:0])})
      else $error("immediate not sign extended");
   a_imm_zero: assert property (immKind == crf_pkg::CRF_IMM_ZERO |=>
      immExt == {24'h0, $past(instr[7:0])})
      else $error("immediate not zero extended");
   a_word_align: assert property (memReq.valid && !memReq.isStack &&
      memReq.size == crf_pkg::CRF_SZ_WORD |=>
      addrError == $past(memReq.addr[0])) else $error("word align check");
   a_long_align: assert property (memReq.valid && !memReq.isStack &&
      memReq.size == crf_pkg::CRF_SZ_LONG |=>
      addrError == ($past(memReq.addr[1:0]) != 2'h0))
      else $error("long align check");
   a_stack_long: assert property (memReq.valid && memReq.isStack |=>
      addrError == ($past(memReq.size) != crf_pkg::CRF_SZ_LONG ||
      $past(memReq.addr[1:0]) != 2'h0)) else $error("stack access check");
   a_ctrl_reset: assert property ($past(rst) |-> vectorBase == 32'h0 &&
      statusWord[7:4] == 4'hf && (statusWord & ~32'h3f3) == 32'h0)
      else $error("control register reset value");
endmodule // crf_register_file_sva
bind crf_register_file crf_register_file_sva chk_u (.*);
`default_nettype wire

// *** tb/crf_register_file_tb.sv ***
// self-checking bench for the register file
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module crf_register_file_tb;
   logic clk = 1'b0, rst = 1'b1, vecLoad = 1'b0, ctrlWe = 1'b0;
   logic macWe = 1'b0, pcWe = 1'b0, ldValid = 1'b0;
   logic [3:0] rdIdxA = 4'h0, rdIdxB = 4'h0;
   logic [1:0] memAddr = 2'h0;
   logic [15:0] instr = 16'h0;
   logic [31:0] vecPc = 32'h0, vecSp = 32'h0, ctrlWdata = 32'h0;
   logic [31:0] macHiIn = 32'h0, macLoIn = 32'h0, pcIn = 32'h0;
   crf_pkg::crf_wr_t wr = '0;
   crf_pkg::crf_ctrl_t ctrlSel = crf_pkg::CRF_CR_SR;
   crf_pkg::crf_size_t ldSize = crf_pkg::CRF_SZ_BYTE;
   crf_pkg::crf_immext_t immKind = crf_pkg::CRF_IMM_SIGN;
   crf_pkg::crf_mem_req_t memReq = '0;
   logic [31:0] rdDataA, rdDataB, indexReg, stackPtr, statusWord, globalBase;
   logic [31:0] vectorBase, macHigh, macLow, procReturn, progCounter;
   logic [31:0] ldRaw, ldExt, immExt, pcRelAddr;
   logic addrError;
   int err_count = 0, checks = 0;
   always #5 clk = ~clk;
   crf_register_file dut_u (.*);
   crf_mem_model mem_u (.clk(clk), .addr(memAddr), .rdata(ldRaw));
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_vec;
      #1;
      `CHK(statusWord[7:4], 4'hf)
      `CHK(vectorBase, 32'h0)
      @(posedge clk);
      vecPc <= 32'h0000_0100;
      vecSp <= 32'h0000_fffc;
      vecLoad <= 1'b1;
      @(posedge clk);
      vecLoad <= 1'b0;
      #1;
      `CHK(progCounter, 32'h0000_0100)
      `CHK(stackPtr, 32'h0000_fffc)
      $display("vector load test done");
   endtask
   task automatic t_gpr;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         wr <= '{1'b1, 4'(i), {8'(i), 24'h5ac3e1}};
         rdIdxA <= 4'(i);
         rdIdxB <= 4'(i - 1);
         @(posedge clk);
         wr <= '0;
         #1;
         `CHK(rdDataA, {8'(i), 24'h5ac3e1})
         if (i > 0) `CHK(rdDataB, {8'(i - 1), 24'h5ac3e1})
      end
      `CHK(indexReg, 32'h005a_c3e1)
      `CHK(stackPtr, 32'h0f5a_c3e1)
      $display("general register test done");
   endtask
   task automatic t_ctrl;
      for (int s = 0; s < 6; s++) begin
         @(posedge clk);
         ctrlWe <= 1'b1;
         ctrlSel <= crf_pkg::crf_ctrl_t'(s);
         ctrlWdata <= 32'hffff_fff0 | 32'(s);
      end
      @(posedge clk);
      macWe <= 1'b1;
      macHiIn <= 32'h8765_4321;
      macLoIn <= 32'h0fed_cba9;
      ctrlSel <= crf_pkg::CRF_CR_MAC_HIGH;
      pcWe <= 1'b1;
      pcIn <= 32'h0000_1002;
      @(posedge clk);
      {macWe, ctrlWe, pcWe} <= 3'h0;
      #1;
      `CHK(statusWord, 32'h0000_03f0)
      `CHK(globalBase, 32'hffff_fff1)
      `CHK(vectorBase, 32'hffff_fff2)
      `CHK(procReturn, 32'hffff_fff5)
      `CHK(macHigh, 32'h8765_4321)
      `CHK(macLow, 32'h0fed_cba9)
      `CHK(progCounter, 32'h0000_1002)
      $display("control register test done");
   endtask
   task automatic t_ld;
      logic [1:0] sz [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
      logic [31:0] ex [4] = '{32'hffff_ff80, 32'hffff_8001, 32'h1234_5678,
                              32'h0000_007f};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         memAddr <= 2'(i);
         @(posedge clk);
         ldValid <= 1'b1;
         ldSize <= crf_pkg::crf_size_t'(sz[i]);
         @(posedge clk);
         ldValid <= 1'b0;
         #1;
         `CHK(ldExt, ex[i])
      end
      $display("load extension test done");
   endtask
   task automatic t_imm;
      logic [15:0] ins [4] = '{16'h0085, 16'h4085, 16'h007f, 16'h40ff};
      logic [31:0] ei [4] = '{32'hffff_ff85, 32'h85, 32'h7f, 32'hff};
      logic [31:0] er [4] = '{32'h110c, 32'h1214, 32'h1100, 32'h13fc};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         instr <= ins[i];
         immKind <= crf_pkg::crf_immext_t'(2'(i % 2));
         @(posedge clk);
         #1;
         `CHK(immExt, ei[i])
         `CHK(pcRelAddr, er[i])
      end
      $display("immediate test done");
   endtask
   task automatic t_align;
      // size, stack, low address bits, expected error
      logic [5:0] tv [8] = '{6'b000110, 6'b010011, 6'b010100, 6'b100101,
                             6'b100000, 6'b101000, 6'b011101, 6'b101011};
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         memReq <= '{1'b1, crf_pkg::crf_size_t'(tv[i][5:4]), tv[i][3],
                     {30'h800, tv[i][2:1]}};
         @(posedge clk);
         memReq <= '0;
         #1;
         `CHK(addrError, tv[i][0])
      end
      $display("alignment test done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_vec;
      t_gpr;
      t_ctrl;
      t_ld;
      t_imm;
      t_align;
      stop_test;
   end
   // guard against a hung sequence
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      stop_test;
   end
endmodule // crf_register_file_tb
`default_nettype wire

// *** verilog/crf_cfg.svh ***
// constants for the cpu register file and operand formatter
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH
`define CRF_IDX_R0       4'h0
`define CRF_IDX_SP       4'hf
`define CRF_IMASK_LSB    4
`define CRF_IMASK_ONES   4'hf
`define CRF_SR_USED      32'h0000_03f3
`define CRF_SR_RESET     32'h0000_00f0
`define CRF_VBR_RESET    32'h0000_0000
`define CRF_BYTE_BITS    8
`define CRF_WORD_BITS    16
`define CRF_WORD_ALIGN   2'h1
`define CRF_LONG_ALIGN   2'h3
`define CRF_NUM_GPR      16
`define CRF_IMM_MSB      7
`define CRF_IMM_LSB      0
`define CRF_LONG_SEL     14
`define CRF_WORD_SHIFT   1
`define CRF_LONG_SHIFT   2
`endif

// *** verilog/crf_pkg.sv ***
// types shared by the cpu register file
package crf_pkg;
   typedef enum logic [1:0] {
      CRF_SZ_BYTE = 2'h0,
      CRF_SZ_WORD = 2'h1,
      CRF_SZ_LONG = 2'h2
   } crf_size_t;

   typedef enum logic [1:0] {
      CRF_IMM_SIGN = 2'h0,
      CRF_IMM_ZERO = 2'h1
   } crf_immext_t;

   typedef enum logic [2:0] {
      CRF_CR_SR   = 3'h0,
      CRF_CR_GBR  = 3'h1,
      CRF_CR_VBR  = 3'h2,
      CRF_CR_MAC_HIGH = 3'h3,
      CRF_CR_MAC_LOW = 3'h4,
      CRF_CR_PR   = 3'h5
   } crf_ctrl_t;

   typedef struct packed {
      logic        valid;
      crf_size_t   size;
      logic        isStack;
      logic [31:0] addr;
   } crf_mem_req_t;

   typedef struct packed {
      logic        valid;
      logic [3:0]  idx;
      logic [31:0] data;
   } crf_wr_t;
endpackage

// *** verilog/crf_register_file.sv ***
// cpu register set with operand extension and alignment checking
//
// Operation
// - sixteen 32-bit general registers for data and address work
// - register zero also serves as index register, read on its own port
// - register fifteen is the stack pointer for exception save/restore
// - status_word, global_base and vector_base are 32-bit control registers
// - global_base supplies the base for peripheral indirect addressing
// - mac_high and mac_low hold multiply and accumulate results
// - procedure_return and program counter are 32-bit system registers
// - stack pointer loads vector table value at reset; others undefined
// - program counter loads vector table value at reset
// - interrupt mask bits reset to ones, reserved zero, vector_base zero
// - byte and word memory loads are sign-extended to 32 bits
// - misaligned word or long accesses raise an address error
// - stack accesses must be long words at multiples of four
// - eight-bit immediates come from the instruction code
// - move, add and compare-equal immediates are sign-extended
// - test and logical immediates are zero-extended
// - word and long immediates are pc-relative memory loads
`timescale 1ns/100ps
`default_nettype none
`include "crf_cfg.svh"

module crf_register_file #(
   parameter int DATA_W = 32
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // vector table fetch at reset
   input  wire logic                 vecLoad,
   input  wire logic [DATA_W-1:0]    vecPc,
   input  wire logic [DATA_W-1:0]    vecSp,
   // read ports
   input  wire logic [3:0]           rdIdxA,
   input  wire logic [3:0]           rdIdxB,
   output logic      [DATA_W-1:0]    rdDataA,
   output logic      [DATA_W-1:0]    rdDataB,
   output logic      [DATA_W-1:0]    indexReg,
   output logic      [DATA_W-1:0]    stackPtr,
   // general write port
   input  wire crf_pkg::crf_wr_t     wr,
   // control and system register access
   input  wire logic                 ctrlWe,
   input  wire crf_pkg::crf_ctrl_t   ctrlSel,
   input  wire logic [DATA_W-1:0]    ctrlWdata,
   input  wire logic                 macWe,
   input  wire logic [DATA_W-1:0]    macHiIn,
   input  wire logic [DATA_W-1:0]    macLoIn,
   output logic      [DATA_W-1:0]    statusWord,
   output logic      [DATA_W-1:0]    globalBase,
   output logic      [DATA_W-1:0]    vectorBase,
   output logic      [DATA_W-1:0]    macHigh,
   output logic      [DATA_W-1:0]    macLow,
   output logic      [DATA_W-1:0]    procReturn,
   // program counter
   input  wire logic                 pcWe,
   input  wire logic [DATA_W-1:0]    pcIn,
   output logic      [DATA_W-1:0]    progCounter,
   // memory load extension
   input  wire logic                 ldValid,
   input  wire crf_pkg::crf_size_t   ldSize,
   input  wire logic [DATA_W-1:0]    ldRaw,
   output logic      [DATA_W-1:0]    ldExt,
   // immediate extension
   input  wire logic [15:0]          instr,
   input  wire crf_pkg::crf_immext_t immKind,
   output logic      [DATA_W-1:0]    immExt,
   output logic      [DATA_W-1:0]    pcRelAddr,
   // alignment check
   input  wire crf_pkg::crf_mem_req_t memReq,
   output logic                      addrError
);

   // register storage, decoded strobes and next values
   logic [DATA_W-1:0]         gpr [0:`CRF_NUM_GPR-1];
   logic [DATA_W-1:0]         next_rdDataA;
   logic [DATA_W-1:0]         next_rdDataB;
   logic [DATA_W-1:0]         next_indexReg;
   logic [DATA_W-1:0]         next_stackPtr;
   logic [DATA_W-1:0]         next_progCounter;
   logic [DATA_W-1:0]         next_ldExt;
   logic [DATA_W-1:0]         next_immExt;
   logic [DATA_W-1:0]         next_pcRel;
   logic [DATA_W-1:0]         longBase;
   logic [DATA_W-1:0]         wordDisp;
   logic [DATA_W-1:0]         longDisp;
   logic [`CRF_BYTE_BITS-1:0] immField;
   logic                      immSign;
   logic                      next_addrError;
   logic                      wrHitA;
   logic                      wrHitB;
   logic                      wrHitIdx;
   logic                      wrHitSp;
   logic                      ctrlSr;
   logic                      ctrlGbr;
   logic                      ctrlVbr;
   logic                      ctrlMach;
   logic                      ctrlMacl;
   logic                      ctrlPr;
   logic                      misWord;
   logic                      misLong;
   logic                      badStack;

   // one write port; the stack pointer alone also takes the reset vector
   genvar g;
   generate
      for (g = 0; g < `CRF_NUM_GPR; g = g + 1) begin : gen_gpr
         if (g == `CRF_IDX_SP) begin : gen_sp
            always_ff @(posedge clk) begin
               if (vecLoad)
                  gpr[g] <= vecSp;
               else if (wr.valid && wr.idx == 4'(g))
                  gpr[g] <= wr.data;
            end
         end else begin : gen_plain
            // no reset: contents stay undefined until first written
            always_ff @(posedge clk) begin
               if (wr.valid && wr.idx == 4'(g))
                  gpr[g] <= wr.data;
            end
         end
      end
   endgenerate

   // write hits feed the same-cycle forwarding paths
   always_comb begin
      wrHitA   = wr.valid && wr.idx == rdIdxA;
      wrHitB   = wr.valid && wr.idx == rdIdxB;
      wrHitIdx = wr.valid && wr.idx == `CRF_IDX_R0;
      wrHitSp  = wr.valid && wr.idx == `CRF_IDX_SP;
   end

   // forwarding lets a dependent instruction issue behind its producer
   always_comb begin
      next_rdDataA  = wrHitA ? wr.data : gpr[rdIdxA];
      next_rdDataB  = wrHitB ? wr.data : gpr[rdIdxB];
      next_indexReg = wrHitIdx ? wr.data : gpr[`CRF_IDX_R0];
      if (vecLoad)
         next_stackPtr = vecSp;
      else if (wrHitSp)
         next_stackPtr = wr.data;
      else
         next_stackPtr = gpr[`CRF_IDX_SP];
   end

   // read port a
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         rdDataA <= '0;
      else
         rdDataA <= next_rdDataA;
   end

   // read port b
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         rdDataB <= '0;
      else
         rdDataB <= next_rdDataB;
   end

   // index register copy for the fixed-operand forms
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         indexReg <= '0;
      else
         indexReg <= next_indexReg;
   end

   // stack pointer copy for exception save and restore
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         stackPtr <= '0;
      else
         stackPtr <= next_stackPtr;
   end

   // control register write strobes; unlisted selects are ignored
   always_comb begin
      ctrlSr   = ctrlWe && ctrlSel == crf_pkg::CRF_CR_SR;
      ctrlGbr  = ctrlWe && ctrlSel == crf_pkg::CRF_CR_GBR;
      ctrlVbr  = ctrlWe && ctrlSel == crf_pkg::CRF_CR_VBR;
      ctrlMach = ctrlWe && ctrlSel == crf_pkg::CRF_CR_MAC_HIGH;
      ctrlMacl = ctrlWe && ctrlSel == crf_pkg::CRF_CR_MAC_LOW;
      ctrlPr   = ctrlWe && ctrlSel == crf_pkg::CRF_CR_PR;
   end

   // reserved status bits can never be set by software
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         statusWord <= `CRF_SR_RESET;
      else if (ctrlSr)
         statusWord <= ctrlWdata & `CRF_SR_USED;
   end

   // vector base starts at zero so early exceptions find their table
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         vectorBase <= `CRF_VBR_RESET;
      else if (ctrlVbr)
         vectorBase <= ctrlWdata;
   end

   // undefined at reset; no reset keeps these registers cheap
   always_ff @(posedge clk) begin
      if (ctrlGbr)
         globalBase <= ctrlWdata;
   end

   // subroutine return address
   always_ff @(posedge clk) begin
      if (ctrlPr)
         procReturn <= ctrlWdata;
   end

   // multiplier result wins over a software write in the same cycle
   always_ff @(posedge clk) begin
      if (macWe)
         macHigh <= macHiIn;
      else if (ctrlMach)
         macHigh <= ctrlWdata;
   end

   // low half follows the same priority as the high half
   always_ff @(posedge clk) begin
      if (macWe)
         macLow <= macLoIn;
      else if (ctrlMacl)
         macLow <= ctrlWdata;
   end

   // vector fetch outranks a jump in the same cycle
   always_comb begin
      if (vecLoad)
         next_progCounter = vecPc;
      else if (pcWe)
         next_progCounter = pcIn;
      else
         next_progCounter = progCounter;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         progCounter <= '0;
      else
         progCounter <= next_progCounter;
   end

   // memory loads are sign-extended from their own top bit
   always_comb begin
      case (ldSize)
         crf_pkg::CRF_SZ_BYTE: begin
            next_ldExt = {{(DATA_W-`CRF_BYTE_BITS){ldRaw[`CRF_BYTE_BITS-1]}},
                          ldRaw[`CRF_BYTE_BITS-1:0]};
         end
         crf_pkg::CRF_SZ_WORD: begin
            next_ldExt = {{(DATA_W-`CRF_WORD_BITS){ldRaw[`CRF_WORD_BITS-1]}},
                          ldRaw[`CRF_WORD_BITS-1:0]};
         end
         default: begin
            next_ldExt = ldRaw;
         end
      endcase
   end

   // holds the last load while no new one arrives
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         ldExt <= '0;
      else if (ldValid)
         ldExt <= next_ldExt;
   end

   // the byte immediate always sits in the low field of the opcode
   always_comb begin
      immField = instr[`CRF_IMM_MSB:`CRF_IMM_LSB];
      immSign  = immField[`CRF_BYTE_BITS-1];
   end

   // arithmetic forms sign-extend, logical forms zero-extend
   always_comb begin
      case (immKind)
         crf_pkg::CRF_IMM_SIGN: begin
            next_immExt = {{(DATA_W-`CRF_BYTE_BITS){immSign}},
                           immField};
         end
         crf_pkg::CRF_IMM_ZERO: begin
            next_immExt = {{(DATA_W-`CRF_BYTE_BITS){1'b0}},
                           immField};
         end
         default: begin
            next_immExt = {{(DATA_W-`CRF_BYTE_BITS){1'b0}},
                           immField};
         end
      endcase
   end

   // word and long immediates come from a pc-relative table
   always_comb begin
      longBase = progCounter & ~DATA_W'(`CRF_LONG_ALIGN);
      wordDisp = DATA_W'(immField) << `CRF_WORD_SHIFT;
      longDisp = DATA_W'(immField) << `CRF_LONG_SHIFT;
      if (instr[`CRF_LONG_SEL])
         next_pcRel = longBase + longDisp;
      else
         next_pcRel = progCounter + wordDisp;
   end

   // registered so the operand lines up with the execute stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         immExt <= '0;
      else
         immExt <= next_immExt;
   end

   // table address, one cycle after the opcode
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         pcRelAddr <= '0;
      else
         pcRelAddr <= next_pcRel;
   end

   // a misaligned stack access would corrupt a saved pc or status word
   always_comb begin
      misWord  = memReq.size == crf_pkg::CRF_SZ_WORD
              && (memReq.addr[1:0] & `CRF_WORD_ALIGN) != 2'h0;
      misLong  = memReq.size == crf_pkg::CRF_SZ_LONG
              && (memReq.addr[1:0] & `CRF_LONG_ALIGN) != 2'h0;
      badStack = memReq.isStack
              && (memReq.size != crf_pkg::CRF_SZ_LONG
                  || (memReq.addr[1:0] & `CRF_LONG_ALIGN) != 2'h0);
      next_addrError = memReq.valid
                    && (misWord || misLong || badStack);
   end

   // data of a flagged access is not guaranteed; the flag is the answer
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         addrError <= 1'b0;
      else
         addrError <= next_addrError;
   end

endmodule // crf_register_file
`default_nettype wire
